// [pkg/adccs_pkg.sv]
package adccs_pkg;
    // register byte addresses on the avalon slave (word aligned)
    localparam logic [3:0] ADDR_SETUP     = 4'h0;
    localparam logic [3:0] ADDR_STATUS    = 4'h4;
    localparam logic [3:0] ADDR_ZSCOEF    = 4'h8;
    localparam logic [3:0] ADDR_FSCOEF    = 4'hc;
    // setup register field positions
    localparam int SETUP_MODE_LO_BIT = 0;
    localparam int SETUP_MODE_HI_BIT = 1;
    localparam int SETUP_BIPOLAR_BIT = 2;
    localparam int SETUP_GAIN_LO_BIT = 3;
    localparam int SETUP_GAIN_HI_BIT = 4;
    localparam int SETUP_RATE_LO_BIT = 8;
    localparam int SETUP_RATE_HI_BIT = 15;
    // calibration mode codes
    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_SELF    = 2'h1;
    localparam logic [1:0] MODE_SYS_ZS  = 2'h2;
    localparam logic [1:0] MODE_SYS_FS  = 2'h3;
    // reset values, nominal coefficients
    localparam logic [15:0] SETUP_RESET    = 16'h0100;
    localparam logic [23:0] ZSCOEF_RESET   = 24'h1f4000;
    localparam logic [23:0] FSCOEF_RESET   = 24'h5761ab;
    localparam logic [15:0] MIDSCALE_CODE  = 16'h8000;
    // timing in output-rate periods
    localparam int CAL_STEP_PERIODS = 3;
    localparam int CONV_PERIODS     = 3;
    localparam int SETUP_OVERHEAD   = 0;
    // modulator cycle: master clock divided by 128
    localparam int MOD_DIV          = 128;
    localparam int MCLK_HZ          = 2457600;
    localparam int MOD_RATE_HZ      = 19200;
    localparam int CLOCK_HZ         = 25000000;
endpackage

// [verilog/adccs_sequencer.sv]
// What this block does
// (RULE1) writing a calibration code to the mode field starts calibration at any time
// (RULE2) mode 01 runs self calibration: zero-scale then full-scale conversion
// (RULE3) self zero-scale step shorts inputs to bias at selected gain
// (RULE4) self full-scale step converts reference over gain at selected gain
// (RULE5) self calibration lasts six output periods, three per step
// (RULE6) mode field returns to 00 when a calibration finishes
// (RULE7) data ready goes high at start, low only with fresh data word
// (RULE8) self calibration: data ready low nine output periods after command
// (RULE9) data ready may take one modulator cycle to rise
// (RULE10) host ignores data ready one modulator cycle after the command
// (RULE11) bipolar self calibration shorted point maps to midscale
// (RULE12) mode 10 runs system zero-scale on external input, three periods
// (RULE13) system steps: data ready low four output periods after command
// (RULE14) mode 11 runs system full-scale on external input, three periods
// (RULE15) host runs system zero-scale before system full-scale
// (RULE16) host holds calibration voltage stable through the step
// (RULE17) system calibration maps endpoints, or midscale and full scale bipolar; the block only removes the zero-scale coefficient
// (RULE18) lone system step updates only its own coefficient
// (RULE19) zero and full results go to their coefficient registers
// (RULE20) modulator runs at master clock over 128, filter decimates to output rate
// (RULE21) host should recalibrate after gain, notch, polarity or environment change
// (RULE22) unipolar output straight binary, bipolar offset binary
// (RULE23) reset loads defaults and nominal coefficients
// (RULE24) mode field reads nonzero and data frozen while calibrating
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module adccs_sequencer #(
    parameter int MOD_DIV = adccs_pkg::MOD_DIV
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        modClock,
    input  wire logic [23:0] modSample,
    output logic             shortToBias,
    output logic             refOverGain,
    output logic [1:0]       gainSel,
    output logic             data_ready_n,
    output logic [15:0]      dataWord
);
    typedef enum logic [2:0] {ADCCS_IDLE, ADCCS_ZERO, ADCCS_FULL, ADCCS_CONV} adccs_state_e;

    localparam int MODCNT_W = $clog2(MOD_DIV);

    adccs_state_e state_reg, state_next;
    logic [15:0] setup_reg;
    logic [23:0] zsCoef_reg, fsCoef_reg;
    logic [15:0] dataWord_reg;
    logic        dataReadyN_reg;
    logic [7:0]  decimCnt_reg;
    logic [1:0]  periodCnt_reg;
    logic [MODCNT_W-1:0] modCnt_reg;
    logic [25:0] accum_reg;
    logic        readPend_reg;
    logic        sysCal_reg;
    logic        modSync1_reg, modSync2_reg, modSync3_reg;

    // master clock pin is foreign: two flops before any logic
    always_ff @(posedge clock) begin
        modSync1_reg <= modClock;
        modSync2_reg <= modSync1_reg;
        modSync3_reg <= modSync2_reg;
    end

    wire mclkRise = modSync2_reg & ~modSync3_reg;

    // modulator tick every MOD_DIV master clocks
    wire modTick = mclkRise && (modCnt_reg == MODCNT_W'(MOD_DIV - 1)); // [RULE20]

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            modCnt_reg <= '0;
        end else if (mclkRise) begin
            modCnt_reg <= modTick ? '0 : modCnt_reg + 1'b1;
        end
    end

    // output-rate period = (rate field + 1) modulator samples
    wire [7:0] rateDiv    = setup_reg[adccs_pkg::SETUP_RATE_HI_BIT:adccs_pkg::SETUP_RATE_LO_BIT];
    wire       periodTick = modTick && (decimCnt_reg >= rateDiv); // [RULE20]

    // bus decode
    wire wrSetup = avs_write && (avs_address == adccs_pkg::ADDR_SETUP) && avs_byteenable[0];
    wire [1:0] wrMode = avs_writedata[adccs_pkg::SETUP_MODE_HI_BIT:adccs_pkg::SETUP_MODE_LO_BIT];
    wire calStart = wrSetup && (wrMode != adccs_pkg::MODE_NORMAL); // [RULE1]
    wire [1:0] curMode = setup_reg[adccs_pkg::SETUP_MODE_HI_BIT:adccs_pkg::SETUP_MODE_LO_BIT];
    wire stepDone = periodTick && (periodCnt_reg == 2'(adccs_pkg::CAL_STEP_PERIODS - 1)); // [RULE5]
    // a system step is followed by one plain conversion, a self calibration by a full one
    wire convEnd  = sysCal_reg ? periodTick : stepDone; // [RULE8] [RULE13]
    wire bipolar  = setup_reg[adccs_pkg::SETUP_BIPOLAR_BIT];

    // filtered result: averaged sample, recoded for polarity
    wire [23:0] avgSample = accum_reg[25:2];
    // zero-scale coefficient removed; gain slope is left to the host, which reads both coefficients
    wire [23:0] netSample = avgSample - zsCoef_reg; // [RULE19] [RULE17]
    wire        belowZero = avgSample < zsCoef_reg;
    wire [15:0] rawWord   = (!bipolar && belowZero) ? 16'h0000 : netSample[23:8]; // unipolar clamps at zero
    wire [15:0] codedWord = bipolar ? (rawWord ^ adccs_pkg::MIDSCALE_CODE) : rawWord; // [RULE22] [RULE11] [RULE17]

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ADCCS_IDLE: begin
                if (calStart) begin
                    state_next = (wrMode == adccs_pkg::MODE_SYS_FS) ? ADCCS_FULL : ADCCS_ZERO; // [RULE2] [RULE14]
                end
            end
            ADCCS_ZERO: begin
                if (calStart) begin
                    state_next = (wrMode == adccs_pkg::MODE_SYS_FS) ? ADCCS_FULL : ADCCS_ZERO;
                end else if (stepDone) begin
                    state_next = (curMode == adccs_pkg::MODE_SELF) ? ADCCS_FULL : ADCCS_CONV; // [RULE5] [RULE12]
                end
            end
            ADCCS_FULL: begin
                if (calStart) begin
                    state_next = (wrMode == adccs_pkg::MODE_SYS_FS) ? ADCCS_FULL : ADCCS_ZERO;
                end else if (stepDone) begin
                    state_next = ADCCS_CONV;
                end
            end
            ADCCS_CONV: begin
                if (calStart) begin
                    state_next = (wrMode == adccs_pkg::MODE_SYS_FS) ? ADCCS_FULL : ADCCS_ZERO;
                end else if (convEnd) begin
                    state_next = ADCCS_IDLE; // [RULE8] [RULE13]
                end
            end
            default: state_next = ADCCS_IDLE;
        endcase
    end

    // first tick of a period reloads, so a steady input reads back exactly
    wire [25:0] accumNext = (decimCnt_reg == 8'h00) ? {modSample, 2'h0} :
                            accum_reg + {2'h0, modSample} - {2'h0, accum_reg[25:2]};

    // step counters restart on every command so timing counts from it
    always_ff @(posedge clock) begin
        if (sys_rst || calStart) begin
            decimCnt_reg  <= 8'h00;
            periodCnt_reg <= 2'h0;
            accum_reg     <= 26'h0000000;
        end else if (periodTick) begin
            decimCnt_reg  <= 8'h00;
            periodCnt_reg <= stepDone ? 2'h0 : periodCnt_reg + 2'h1;
            accum_reg     <= accumNext;
        end else if (modTick) begin
            decimCnt_reg  <= decimCnt_reg + 8'h01;
            accum_reg     <= accumNext;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg  <= ADCCS_IDLE;
            sysCal_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (calStart) begin
                sysCal_reg <= (wrMode != adccs_pkg::MODE_SELF); // [RULE13]
            end
        end
    end

    // setup register: host writes, hardware clears mode when calibration done
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            setup_reg <= adccs_pkg::SETUP_RESET; // [RULE23]
        end else if (wrSetup) begin
            setup_reg[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1]) begin
                setup_reg[15:8] <= avs_writedata[15:8];
            end
        end else if (stepDone && (state_reg == ADCCS_FULL ||
                     (state_reg == ADCCS_ZERO && curMode == adccs_pkg::MODE_SYS_ZS))) begin
            setup_reg[adccs_pkg::SETUP_MODE_HI_BIT:adccs_pkg::SETUP_MODE_LO_BIT] <= adccs_pkg::MODE_NORMAL; // [RULE6]
        end
    end

    // coefficients: each step writes only its own register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            zsCoef_reg <= adccs_pkg::ZSCOEF_RESET; // [RULE23]
            fsCoef_reg <= adccs_pkg::FSCOEF_RESET;
        end else if (stepDone && !calStart && state_reg == ADCCS_ZERO) begin
            zsCoef_reg <= avgSample; // [RULE19] [RULE18]
        end else if (stepDone && !calStart && state_reg == ADCCS_FULL) begin
            fsCoef_reg <= avgSample; // [RULE19] [RULE18]
        end
    end

    // data word and ready flag; no new data while calibrating
    wire convDone = periodTick && (state_reg == ADCCS_IDLE || (state_reg == ADCCS_CONV && convEnd));
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dataWord_reg   <= 16'h0000;
            dataReadyN_reg <= 1'b1;
        end else if (calStart) begin
            dataReadyN_reg <= 1'b1; // [RULE7] [RULE9]
        end else if (convDone) begin
            dataWord_reg   <= codedWord; // [RULE24]
            dataReadyN_reg <= 1'b0; // [RULE8] [RULE13]
        end
    end

    // analog front-end steering
    assign shortToBias  = (state_reg == ADCCS_ZERO) && (curMode == adccs_pkg::MODE_SELF); // [RULE3]
    assign refOverGain  = (state_reg == ADCCS_FULL) && (curMode == adccs_pkg::MODE_SELF); // [RULE4]
    assign gainSel      = setup_reg[adccs_pkg::SETUP_GAIN_HI_BIT:adccs_pkg::SETUP_GAIN_LO_BIT];
    assign data_ready_n = dataReadyN_reg;
    assign dataWord     = dataWord_reg;

    // avalon slave: writes take one cycle, reads wait one cycle for registered data
    wire rdSetup  = (avs_address == adccs_pkg::ADDR_SETUP);
    wire rdStatus = (avs_address == adccs_pkg::ADDR_STATUS);
    wire rdZs     = (avs_address == adccs_pkg::ADDR_ZSCOEF);
    wire rdFs     = (avs_address == adccs_pkg::ADDR_FSCOEF);
    wire [31:0] rdMux = rdSetup  ? {16'h0000, setup_reg} :
                        rdStatus ? {28'h0000000, state_reg, data_ready_n} :
                        rdZs     ? {8'h00, zsCoef_reg} :
                        rdFs     ? {8'h00, fsCoef_reg} : 32'h00000000;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            readPend_reg <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            readPend_reg <= avs_read && !readPend_reg;
            avs_readdata <= rdMux;
        end
    end

    assign avs_waitrequest = avs_read && !readPend_reg;

    // calibration start forces ready flag high next cycle
    start_ready_a: assert property (@(posedge clock) disable iff (sys_rst) // [RULE7]
        calStart |=> data_ready_n)
        else $error("data ready not high after calibration start");

    // mode reads nonzero while a step runs
    mode_busy_a: assert property (@(posedge clock) disable iff (sys_rst) // [RULE24]
        (state_reg == ADCCS_ZERO || state_reg == ADCCS_FULL) |-> curMode != adccs_pkg::MODE_NORMAL)
        else $error("mode field zero during calibration step");

    // data word frozen during the zero-scale step
    data_frozen_a: assert property (@(posedge clock) disable iff (sys_rst) // [RULE24]
        (state_reg == ADCCS_ZERO && !calStart) |=> $stable(dataWord_reg))
        else $error("data word changed during calibration");

    // mode cleared at the end of the full step
    mode_clear_a: assert property (@(posedge clock) disable iff (sys_rst) // [RULE6]
        (stepDone && state_reg == ADCCS_FULL && !wrSetup) |=> curMode == adccs_pkg::MODE_NORMAL)
        else $error("mode not cleared after calibration");

    // self calibration goes zero then full
    self_order_a: assert property (@(posedge clock) disable iff (sys_rst) // [RULE2]
        (state_reg == ADCCS_ZERO && stepDone && !calStart && curMode == adccs_pkg::MODE_SELF)
        |=> state_reg == ADCCS_FULL)
        else $error("self calibration skipped full-scale step");

    // system zero-scale leaves full coefficient alone
    coef_keep_a: assert property (@(posedge clock) disable iff (sys_rst) // [RULE18]
        (state_reg == ADCCS_ZERO) |=> $stable(fsCoef_reg))
        else $error("full-scale coefficient changed during zero step");

    // shorting only in self zero step
    short_only_a: assert property (@(posedge clock) disable iff (sys_rst) // [RULE3]
        shortToBias |-> (state_reg == ADCCS_ZERO && curMode == adccs_pkg::MODE_SELF))
        else $error("input shorted outside self zero step");

    // ready falls only at end of conversion
    ready_fall_a: assert property (@(posedge clock) disable iff (sys_rst) // [RULE8]
        $fell(data_ready_n) |-> $past(convDone))
        else $error("data ready fell without a conversion");

    // a system step ends after one plain conversion period
    sequence sys_conv_end_s;
        state_reg == ADCCS_CONV && sysCal_reg && periodTick && !calStart;
    endsequence
    sys_conv_a: assert property (@(posedge clock) disable iff (sys_rst) // [RULE13]
        sys_conv_end_s |=> (!data_ready_n && state_reg == ADCCS_IDLE))
        else $error("system step conversion did not end after one period");
endmodule
`default_nettype wire

// [verification/adccs_mod_model.sv]
`timescale 1ns/1ps
`default_nettype none
// modulator stand-in: free running master clock, sample follows the switches
module adccs_mod_model #(
    parameter logic [23:0] BIAS_LVL = 24'h012345,
    parameter logic [23:0] REF_LVL  = 24'h6a5000
) (
    output logic             modClock,
    output logic      [23:0] modSample,
    input  wire logic        shortToBias,
    input  wire logic        refOverGain,
    input  wire logic [23:0] extLevel
);
    // master clock never stops; offset keeps its edges off the system edges
    initial begin
        modClock = 1'b0;
        #7;
        forever #80 modClock = ~modClock;
    end
    // internal points override the external input, which the bench holds steady
    assign modSample = shortToBias ? BIAS_LVL : (refOverGain ? REF_LVL : extLevel);
endmodule
`default_nettype wire

// [verification/adc_calibration_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_calibration_sequencer_tb;
    localparam int TICK = 16; // modulator tick: 4 master clocks of 160 ns
    localparam int PER  = 2 * TICK; // rate field 1 gives two ticks per period
    localparam int TOL  = TICK + 6; // tick phase plus polling granularity
    logic        clock;
    logic        sys_rst;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        modClock;
    logic [23:0] modSample;
    logic        shortToBias;
    logic        refOverGain;
    logic [1:0]  gainSel;
    logic        data_ready_n;
    logic [15:0] dataWord;
    logic [23:0] extLevel;
    logic [31:0] q;
    int          n_mismatch;
    int          cmp_count;

    adccs_sequencer #(.MOD_DIV(4)) i_dut (
        .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .modClock(modClock),
        .modSample(modSample), .shortToBias(shortToBias), .refOverGain(refOverGain),
        .gainSel(gainSel), .data_ready_n(data_ready_n), .dataWord(dataWord)
    );
    adccs_mod_model i_mod (
        .modClock(modClock), .modSample(modSample), .shortToBias(shortToBias),
        .refOverGain(refOverGain), .extLevel(extLevel)
    );

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic wrap_up;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    // cycle counts only; the tolerance covers the modulator tick phase
    task automatic near(input string what, input int exp, input int got);
        cmp_count++;
        if (got < exp - TOL || got > exp + TOL) begin
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
            n_mismatch++;
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        int i;
        avs_address <= adr;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= wd;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0)
                break;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 50) begin
            n_mismatch++;
            wrap_up();
        end
        @(posedge clock);
    endtask

    task automatic t_reset;
        bus(1'b0, adccs_pkg::ADDR_SETUP, 32'h0, q);
        chk("setup", {16'h0, adccs_pkg::SETUP_RESET}, q);
        bus(1'b0, adccs_pkg::ADDR_ZSCOEF, 32'h0, q);
        chk("zero coef", {8'h0, adccs_pkg::ZSCOEF_RESET}, q);
        bus(1'b0, adccs_pkg::ADDR_FSCOEF, 32'h0, q);
        chk("full coef", {8'h0, adccs_pkg::FSCOEF_RESET}, q);
        bus(1'b1, 4'h2, 32'hffff_ffff, q);
        bus(1'b0, 4'h2, 32'h0, q);
        chk("unmapped", 32'h0, q);
    endtask

    // start a calibration and poll setup until the fresh word arrives
    task automatic run_cal(input logic [1:0] code, input logic bip, input int clrExp, input int rdyExp);
        int c;
        int clrAt;
        int refAt;
        logic sawShort;
        clrAt = -1;
        refAt = -1;
        sawShort = 1'b0;
        bus(1'b1, adccs_pkg::ADDR_SETUP, {16'h0, 8'h01, 3'h0, 2'h2, bip, code}, q);
        bus(1'b0, adccs_pkg::ADDR_SETUP, 32'h0, q);
        repeat (TICK) @(posedge clock);
        c = 5 + TICK;
        chk("mode running", {30'h0, code}, {30'h0, q[1:0]});
        chk("ready high", 32'h1, {31'h0, data_ready_n});
        chk("gain", 32'h2, {30'h0, gainSel});
        while (data_ready_n !== 1'b0 && c < 20 * PER) begin
            bus(1'b0, adccs_pkg::ADDR_SETUP, 32'h0, q);
            c += 3;
            if (q[1:0] === 2'h0 && clrAt < 0)
                clrAt = c;
            if (shortToBias === 1'b1)
                sawShort = 1'b1;
            if (refOverGain === 1'b1 && refAt < 0)
                refAt = c;
        end
        chk("ready timeout", 32'h0, {31'h0, data_ready_n});
        if (data_ready_n !== 1'b0)
            wrap_up();
        chk("bias switch", {31'h0, code == adccs_pkg::MODE_SELF}, {31'h0, sawShort});
        if (code == adccs_pkg::MODE_SELF)
            near("full step", 3 * PER, refAt);
        near("mode clear", clrExp, clrAt);
        near("ready low", rdyExp, c);
    endtask

    task automatic chk_coef(input logic [23:0] zs, input logic [23:0] fs);
        bus(1'b0, adccs_pkg::ADDR_ZSCOEF, 32'h0, q);
        chk("zero coef", {8'h0, zs}, q);
        bus(1'b0, adccs_pkg::ADDR_FSCOEF, 32'h0, q);
        chk("full coef", {8'h0, fs}, q);
    endtask

    initial begin
        sys_rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        extLevel = 24'h0a0000;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clock);
        t_reset();
        // calibrate while a normal conversion word is pending
        for (int i = 0; i < 400 && data_ready_n !== 1'b0; i++)
            @(posedge clock);
        chk("ready before cal", 32'h0, {31'h0, data_ready_n});
        if (data_ready_n !== 1'b0)
            wrap_up();
        run_cal(adccs_pkg::MODE_SELF, 1'b0, 6 * PER, 9 * PER);
        chk_coef(24'h012345, 24'h6a5000);
        extLevel <= 24'h023456;
        run_cal(adccs_pkg::MODE_SYS_ZS, 1'b0, 3 * PER, 4 * PER);
        chk_coef(24'h023456, 24'h6a5000);
        chk("zero word", 32'h0, {16'h0, dataWord});
        extLevel <= 24'h5a0000;
        run_cal(adccs_pkg::MODE_SYS_FS, 1'b0, 3 * PER, 4 * PER);
        chk_coef(24'h023456, 24'h5a0000);
        extLevel <= 24'h012345;
        run_cal(adccs_pkg::MODE_SELF, 1'b1, 6 * PER, 9 * PER);
        chk("midscale", {16'h0, adccs_pkg::MIDSCALE_CODE}, {16'h0, dataWord});
        wrap_up();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clock);
        n_mismatch++;
        wrap_up();
    end
endmodule
`default_nettype wire
